//--- logic/drsu_pkg.sv
package drsu_pkg;

	// Internal bus width of the second-stage adder / accumulator
	localparam int DRSU_BUS_W = 44;

	// Legal ranges for the build-time bit positions
	localparam int DRSU_RND_POS_MIN = 6;
	localparam int DRSU_RND_POS_MAX = 21;
	localparam int DRSU_SAT_POS_MIN = 28;
	localparam int DRSU_SAT_POS_MAX = 43;

	// Default positions: 44-bit sum rounded below bit 12, saturated at bit 43
	localparam int DRSU_RND_POS_DEF = 12;
	localparam int DRSU_SAT_POS_DEF = 43;

	// Reset value of the result and overflow registers
	localparam logic [43:0] DRSU_RESULT_RST = 44'h000_0000_0000;
	localparam logic        DRSU_FLAG_RST   = 1'b0;

	// Rounding and saturation flavours, fixed at build time
	typedef enum logic [0:0]
	{
		DRSU_RND_NEAREST_INT  = 1'b0,
		DRSU_RND_NEAREST_EVEN = 1'b1
	} drsu_rnd_mode_type;

	typedef enum logic [0:0]
	{
		DRSU_SAT_ASYMMETRIC = 1'b0,
		DRSU_SAT_SYMMETRIC  = 1'b1
	} drsu_sat_mode_type;

	// Operand signedness as presented by the fabric
	typedef enum logic [1:0]
	{
		DRSU_UU = 2'b00,
		DRSU_US = 2'b01,
		DRSU_SU = 2'b10,
		DRSU_SS = 2'b11
	} drsu_sign_type;

endpackage : drsu_pkg

//--- logic/drsu_stage_if.sv
`timescale 1ns/1ps
`default_nettype none

// Carries one stage's controls and result between top and stage datapath
interface drsu_stage_if;
	import drsu_pkg::*;

	logic [DRSU_BUS_W-1:0] value;
	logic                  signed_val;
	logic                  round_en;
	logic                  sat_en;
	logic [DRSU_BUS_W-1:0] result;
	logic                  overflow;

	modport top
	(
		output value,
		output signed_val,
		output round_en,
		output sat_en,
		input  result,
		input  overflow
	);

	modport stage
	(
		input  value,
		input  signed_val,
		input  round_en,
		input  sat_en,
		output result,
		output overflow
	);

endinterface : drsu_stage_if

`default_nettype wire

//--- logic/drsu_stage.sv
`timescale 1ns/1ps
`default_nettype none

// Combinational round then saturate of one 44-bit value
module drsu_stage
	import drsu_pkg::*;
#(
	parameter drsu_rnd_mode_type RND_MODE = DRSU_RND_NEAREST_INT,
	parameter drsu_sat_mode_type SAT_MODE = DRSU_SAT_ASYMMETRIC,
	parameter int                RND_POS  = DRSU_RND_POS_DEF,
	parameter int                SAT_POS  = DRSU_SAT_POS_DEF
)
(
	// Stage operands and result
	drsu_stage_if.stage st
);

	localparam int W = DRSU_BUS_W;

	// Bit masks derived once from the build-time positions
	localparam logic [W-1:0] LOW_MASK  = (W'(1) << RND_POS) - W'(1);
	localparam logic [W-1:0] HALF      = W'(1) << (RND_POS - 1);
	localparam logic [W-1:0] POS_MAX   = (W'(1) << SAT_POS) - W'(1);
	localparam logic [W-1:0] NEG_MIN   = ~POS_MAX;

	// State of this module is the packed pair of result and flag
	typedef struct packed
	{
		logic [W-1:0] result;
		logic         overflow;
	} drsu_stage_type;

	drsu_stage_type s_nxt;

	// Round, then saturate the rounded value
	always_comb
	begin
		logic [W:0]   ext;
		logic [W:0]   sum;
		logic [W-1:0] rnd;
		logic         tie;
		logic         odd;
		logic         add;
		logic         neg;
		logic [W:0]   lo_lim;
		logic [W:0]   hi_lim;
		ext    = {st.signed_val & st.value[W-1], st.value};
		tie    = (st.value & LOW_MASK) == HALF;
		odd    = st.value[RND_POS];
		// Residue at least half rounds up; even-tie stays put in nearest-even
		add    = (st.value & HALF) != '0;
		if (RND_MODE == DRSU_RND_NEAREST_EVEN && tie && !odd)
		begin
			add = 1'b0;
		end
		// Add half-LSB, then clear the discarded bits
		sum    = ext + {1'b0, HALF};
		if (st.round_en && add)
		begin
			ext = sum;
		end
		if (st.round_en)
		begin
			ext[W-1:0] = ext[W-1:0] & ~LOW_MASK;
		end
		rnd    = ext[W-1:0];
		// Unsigned words are never negative; a carry past the top bit is too large
		neg    = st.signed_val & ext[W];
		// Limits in the extended domain; symmetric floor sits one LSB above
		hi_lim = {1'b0, POS_MAX};
		lo_lim = {1'b1, NEG_MIN};
		if (SAT_MODE == DRSU_SAT_SYMMETRIC)
		begin
			lo_lim = lo_lim + (W+1)'(W'(1) << RND_POS);
		end
		s_nxt.result   = rnd;
		s_nxt.overflow = 1'b0;
		if (st.sat_en)
		begin
			if (!neg && (ext > hi_lim))
			begin
				s_nxt.result   = POS_MAX;
				s_nxt.overflow = 1'b1;
			end
			else if (neg && ($signed(ext) < $signed(lo_lim)))
			begin
				s_nxt.result   = lo_lim[W-1:0];
				s_nxt.overflow = 1'b1;
			end
		end
		else if (!st.signed_val && ext[W])
		begin
			s_nxt.overflow = 1'b1; // Unsigned carry out of the rounding add
		end
	end

	assign st.result   = s_nxt.result;
	assign st.overflow = s_nxt.overflow;

endmodule : drsu_stage

`default_nettype wire

//--- logic/drsu_round_sat.sv
`timescale 1ns/1ps
`default_nettype none

module drsu_round_sat
	import drsu_pkg::*;
#(
	parameter drsu_rnd_mode_type RND_MODE = DRSU_RND_NEAREST_INT,
	parameter drsu_sat_mode_type SAT_MODE = DRSU_SAT_ASYMMETRIC,
	parameter int                RND_POS  = DRSU_RND_POS_DEF,
	parameter int                SAT_POS  = DRSU_SAT_POS_DEF
)
(
	// Clock, enable and clear
	input  wire logic                  mclk,
	input  wire logic                  resetn,
	input  wire logic                  out_ena,
	// Operand signedness
	input  wire logic                  sign_a,
	input  wire logic                  sign_b,
	// First stage (output) value and controls
	input  wire logic [DRSU_BUS_W-1:0] out_value,
	input  wire logic                  out_acc_ovf,
	input  wire logic                  output_round,
	input  wire logic                  output_saturate,
	// Second stage (chainout) value and controls
	input  wire logic [DRSU_BUS_W-1:0] chain_value,
	input  wire logic                  chainout_round,
	input  wire logic                  chainout_saturate,
	// Registered results
	output logic      [DRSU_BUS_W-1:0] out_result,
	output logic                       out_overflow,
	output logic      [DRSU_BUS_W-1:0] chain_result,
	output logic                       chain_overflow
);

	// Positions must fall in the configurable windows of the bus
	if (RND_POS < DRSU_RND_POS_MIN || RND_POS > DRSU_RND_POS_MAX)
	begin : g_bad_rnd_pos
		$error("drsu_round_sat: round position out of range");
	end
	if (SAT_POS < DRSU_SAT_POS_MIN || SAT_POS > DRSU_SAT_POS_MAX)
	begin : g_bad_sat_pos
		$error("drsu_round_sat: saturate position out of range");
	end

	// All registered state of the block
	typedef struct packed
	{
		logic [DRSU_BUS_W-1:0] out_result;
		logic                  out_overflow;
		logic [DRSU_BUS_W-1:0] chain_result;
		logic                  chain_overflow;
	} drsu_state_type;

	drsu_state_type s_r;
	drsu_state_type s_nxt;

	// Result is signed when either operand is signed
	function automatic logic drsu_is_signed(input drsu_sign_type sg);
		drsu_is_signed = (sg != DRSU_UU);
	endfunction : drsu_is_signed

	logic          res_signed;
	drsu_sign_type sign_sel;

	assign sign_sel   = drsu_sign_type'({sign_a, sign_b});
	assign res_signed = drsu_is_signed(sign_sel);

	drsu_stage_if out_if ();
	drsu_stage_if chain_if ();

	// Controls sampled fresh each cycle, no holding
	assign out_if.value        = out_value;
	assign out_if.signed_val   = res_signed;
	assign out_if.round_en     = output_round;
	assign out_if.sat_en       = output_saturate;
	assign chain_if.value      = chain_value;
	assign chain_if.signed_val = res_signed;
	assign chain_if.round_en   = chainout_round;
	assign chain_if.sat_en     = chainout_saturate;

	// First stage round/saturate
	drsu_stage #(
		.RND_MODE (RND_MODE),
		.SAT_MODE (SAT_MODE),
		.RND_POS  (RND_POS),
		.SAT_POS  (SAT_POS)
	) u_out_stage (
		.st (out_if.stage)
	);

	// Second (chainout) stage round/saturate
	drsu_stage #(
		.RND_MODE (RND_MODE),
		.SAT_MODE (SAT_MODE),
		.RND_POS  (RND_POS),
		.SAT_POS  (SAT_POS)
	) u_chain_stage (
		.st (chain_if.stage)
	);

	// Next state: load on enable, otherwise hold
	always_comb
	begin
		s_nxt = s_r;
		if (out_ena)
		begin
			s_nxt.out_result     = out_if.result;
			s_nxt.out_overflow   = out_if.overflow | out_acc_ovf;
			s_nxt.chain_result   = chain_if.result;
			s_nxt.chain_overflow = chain_if.overflow;
		end
	end

	// Single output register bank; no added latency
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			s_r.out_result     <= DRSU_RESULT_RST;
			s_r.out_overflow   <= DRSU_FLAG_RST;
			s_r.chain_result   <= DRSU_RESULT_RST;
			s_r.chain_overflow <= DRSU_FLAG_RST;
		end
		else
		begin
			s_r <= s_nxt;
		end
	end

	assign out_result     = s_r.out_result;
	assign out_overflow   = s_r.out_overflow;
	assign chain_result   = s_r.chain_result;
	assign chain_overflow = s_r.chain_overflow;

endmodule : drsu_round_sat

`default_nettype wire

//--- bench/drsu_round_sat_checker.sv
`timescale 1ns/1ps
`default_nettype none
// Timing and limits of both result registers
module drsu_round_sat_checker
	import drsu_pkg::*;
#(
	parameter drsu_sat_mode_type SAT_MODE = DRSU_SAT_ASYMMETRIC,
	parameter int                RND_POS  = DRSU_RND_POS_DEF,
	parameter int                SAT_POS  = DRSU_SAT_POS_DEF
)
(
	// Clock and clear
	input wire logic                  mclk,
	input wire logic                  resetn,
	// Controls
	input wire logic                  out_ena,
	input wire logic                  sign_a,
	input wire logic                  sign_b,
	input wire logic                  out_acc_ovf,
	input wire logic                  output_round,
	input wire logic                  output_saturate,
	input wire logic                  chainout_round,
	input wire logic                  chainout_saturate,
	// Values and results
	input wire logic [DRSU_BUS_W-1:0] out_value,
	input wire logic [DRSU_BUS_W-1:0] chain_value,
	input wire logic [DRSU_BUS_W-1:0] out_result,
	input wire logic [DRSU_BUS_W-1:0] chain_result,
	input wire logic                  out_overflow,
	input wire logic                  chain_overflow
);
	// Limits in the signed view of the bus
	localparam longint MX = (64'sd1 <<< SAT_POS) - 1;
	localparam longint MN = -MX - 1 + ((SAT_MODE == DRSU_SAT_SYMMETRIC) ? (64'sd1 <<< RND_POS) : 0);
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);
	// Capture steps of a saturating word
	sequence s_out_sat;
		out_ena && output_saturate;
	endsequence
	sequence s_chain_sat;
		out_ena && chainout_saturate;
	endsequence
	a_hold_no_ena: assert property (!out_ena |=> $stable(out_result) && $stable(chain_result))
		else $error("hold");
	a_out_plain: assert property (out_ena && !output_round && !output_saturate |=>
		out_result == $past(out_value) && out_overflow == $past(out_acc_ovf)) else $error("out plain");
	a_chain_plain: assert property (out_ena && !chainout_round && !chainout_saturate |=>
		chain_result == $past(chain_value) && !chain_overflow) else $error("chain plain");
	a_out_round_low: assert property (out_ena && output_round && !output_saturate |=>
		out_result[RND_POS-1:0] == 0) else $error("out low bits");
	a_chain_round_low: assert property (out_ena && chainout_round && !chainout_saturate |=>
		chain_result[RND_POS-1:0] == 0) else $error("chain low bits");
	a_out_sat_range: assert property (s_out_sat |=>
		$signed(out_result) <= MX && $signed(out_result) >= MN) else $error("out range");
	a_chain_sat_range: assert property (s_chain_sat |=>
		$signed(chain_result) <= MX && $signed(chain_result) >= MN) else $error("chain range");
	a_acc_ovf_flag: assert property (out_ena && out_acc_ovf |=> out_overflow)
		else $error("acc flag");
	// Unsigned word with every bit from the half bit up set always carries out of the bus
	a_chain_carry_flag: assert property (out_ena && chainout_round && !chainout_saturate
		&& !sign_a && !sign_b && (&chain_value[DRSU_BUS_W-1:RND_POS-1])
		|=> chain_overflow && chain_result == 0) else $error("chain carry");
endmodule : drsu_round_sat_checker
bind drsu_round_sat drsu_round_sat_checker #(.SAT_MODE(SAT_MODE), .RND_POS(RND_POS),
	.SAT_POS(SAT_POS)) i_drsu_round_sat_checker (.*);
`default_nettype wire

//--- bench/drsu_fabric_model.sv
`timescale 1ns/1ps
`default_nettype none
// Fabric logic presenting the dynamic controls
module drsu_fabric_model
(
	// Requested control word
	input wire logic [7:0] req,
	// Controls towards the slice
	output logic           out_ena,
	output logic           out_acc_ovf,
	output logic           sign_a,
	output logic           sign_b,
	output logic           output_round,
	output logic           output_saturate,
	output logic           chainout_round,
	output logic           chainout_saturate
);
	// Each control is a bit of the requested word, as the sequence asks
	assign {out_ena, out_acc_ovf, sign_a, sign_b} = req[7:4];
	assign {output_round, output_saturate} = req[3:2];
	assign {chainout_round, chainout_saturate} = req[1:0];
endmodule : drsu_fabric_model
`default_nettype wire

//--- bench/tb_drsu_round_sat.sv
`timescale 1ns/1ps
`default_nettype none
module tb_drsu_round_sat;
	import drsu_pkg::*;
	localparam drsu_rnd_mode_type RM = DRSU_RND_NEAREST_EVEN;
	localparam drsu_sat_mode_type SM = DRSU_SAT_SYMMETRIC;
	localparam int RP = 6;
	localparam int SP = 31;
	logic mclk = 1'b0;
	logic resetn = 1'b0;
	logic [7:0] req = 8'h00;
	logic [43:0] out_value = 44'h0, chain_value = 44'h0, out_result, chain_result;
	logic out_ena, out_acc_ovf, sign_a, sign_b, out_overflow, chain_overflow;
	logic output_round, output_saturate, chainout_round, chainout_saturate;
	logic [44:0] eo, ec;
	logic [63:0] seed = 64'h691d;
	logic [63:0] r;
	int fails = 0;
	int n_compared = 0;
	// Ties, clamps, flag, hold, unsigned carry: control word and both values
	logic [7:0] ck[6] = '{8'haa, 8'h8f, 8'ha5, 8'hc0, 8'h2f, 8'h8e};
	logic [43:0] ca[6] = '{44'h0a0, 44'h7ff_ffff_ffff, 44'h800_0000_0000, 44'h123, 44'h1,
		44'hfff_ffff_ffff};
	logic [43:0] cc[6] = '{44'h0e0, 44'h000_7fff_ffe0, 44'hfff_8000_0000, 44'h456, 44'h2,
		44'hfff_ffff_ffe0};
	drsu_fabric_model i_drsu_fabric_model (.*);
	drsu_round_sat #(.RND_MODE(RM), .SAT_MODE(SM), .RND_POS(RP), .SAT_POS(SP))
		i_drsu_round_sat (.*);
	// Free-running clock
	always #5 mclk = ~mclk;
	function automatic logic [63:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 7;
		seed ^= seed << 17;
		return seed;
	endfunction : xs
	// Round then clamp in a wide signed view
	function automatic logic [44:0] f_ref(logic [43:0] v, logic sg, rn, st);
		longint x;
		longint m;
		x = sg ? longint'($signed(v)) : longint'(v);
		if (rn)
			x = ((x >>> RP) + (x[RP-1] &&
				!(RM == DRSU_RND_NEAREST_EVEN && x[RP-2:0] == 0 && !x[RP]))) <<< RP;
		m = (64'sd1 <<< SP) - 1;
		if (st && x > m) return {1'b1, m[43:0]};
		m = -m - 1 + ((SM == DRSU_SAT_SYMMETRIC) ? (64'sd1 <<< RP) : 0);
		if (st && x < m) return {1'b1, m[43:0]};
		return {!sg && x[44], x[43:0]};
	endfunction : f_ref
	task automatic chk(input string nm, input logic [44:0] got, input logic [44:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			fails++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	// Drive just after an edge, compare just after the next
	task automatic step(input logic [7:0] k, input logic [43:0] a, input logic [43:0] c);
		req = k;
		out_value = a;
		chain_value = c;
		if (k[7])
		begin
			eo = f_ref(a, k[5] | k[4], k[3], k[2]) | {k[6], 44'h0};
			ec = f_ref(c, k[5] | k[4], k[1], k[0]);
		end
		@(posedge mclk);
		#1;
		chk("out", {out_overflow, out_result}, eo);
		chk("chain", {chain_overflow, chain_result}, ec);
	endtask : step
	task automatic final_report();
		if (fails == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : final_report
	// Corner table, then two batches of random words, each followed by a clear
	initial
	begin
		eo = '0;
		ec = '0;
		repeat (20) @(posedge mclk);
		#1;
		resetn = 1'b1;
		foreach (ck[i]) step(ck[i], ca[i], cc[i]);
		repeat (2)
		begin
			repeat (2000)
			begin
				r = xs();
				step({r[63:61] != 3'h0, r[60:54]}, $signed(r[43:0]) >>> r[48:44],
					$signed(r[53:10]) >>> r[58:54]);
			end
			resetn = 1'b0;
			#1;
			chk("clear", {out_overflow, out_result, chain_overflow, chain_result} == '0, 45'h1);
			eo = '0;
			ec = '0;
			@(posedge mclk);
			#1;
			resetn = 1'b1;
		end
		final_report();
	end
	// Watchdog against a hang
	initial
	begin
		#200000;
		fails++;
		final_report();
	end
endmodule : tb_drsu_round_sat
`default_nettype wire
